// [mcuis_cpu_model.sv]
`timescale 1ns/1ns
// ***
// cpu and flag sources seen by the sequencer
// ***
module mcuis_cpu_model (
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic        cpu_clk_en,
	input  wire logic        vector_fetch,
	input  wire logic [15:0] vector_addr,
	input  wire logic [7:0]  tmr_set,
	input  wire logic [7:0]  sci_set,
	output logic             instr_done,
	output logic [7:0]       tmr_flags_in,
	output logic [7:0]       sci_flags_in
);
	logic [2:0] cnt;
	logic [7:0] tclr;
	logic [7:0] sclr;

	// the handler clears only the flags behind the vector it was sent to
	always_comb begin
		tclr = 8'h00;
		sclr = 8'h00;
		if (vector_fetch) begin
			case (vector_addr)
				16'h1FF8: tclr = 8'hC0;
				16'h1FF6: tclr = 8'h30;
				16'h1FF4: tclr = 8'h08;
				16'h1FF2: sclr = 8'hF8; // status read then data access
				default: tclr = 8'h00;
			endcase
		end
	end

	// one instruction every 8 cycles, frozen while the cpu clock is gated
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cnt <= 3'h0;
			instr_done <= 1'b0;
			tmr_flags_in <= 8'h00;
			sci_flags_in <= 8'h00;
		end else begin
			cnt <= cpu_clk_en ? cnt + 3'h1 : cnt;
			instr_done <= cpu_clk_en && cnt == 3'h7;
			tmr_flags_in <= (tmr_flags_in | tmr_set) & ~tclr;
			sci_flags_in <= (sci_flags_in | sci_set) & ~sclr;
		end
	end
endmodule : mcuis_cpu_model

// [mcuis_ctrl.sv]
// Design decision made here: the APB slave port.
`timescale 1ns/1ns
module mcuis_ctrl #(
	parameter int ADDR_W = 10
) (
	input  wire logic              clk_sys,
	input  wire logic              rst,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              irq_pin,
	input  wire logic [7:0]        tmr_flags_in,
	input  wire logic [7:0]        sci_flags_in,
	input  wire logic              instr_done,
	input  wire logic              soft_trap_fetch,
	input  wire logic              trap_return_exec,
	input  wire logic              stacked_mask,
	input  wire logic              mask_set_exec,
	input  wire logic              mask_clr_exec,
	input  wire logic              call_exec,
	input  wire logic              return_exec,
	input  wire logic              stop_exec,
	input  wire logic              wait_exec,
	output logic                   int_mask_flag,
	output logic                   stack_push,
	output logic      [15:0]       stack_ptr,
	output logic                   vector_fetch,
	output logic      [15:0]       vector_addr,
	output logic                   osc_en,
	output logic                   cpu_clk_en,
	output logic                   timer_clk_en,
	output logic      [7:0]        timer_control,
	output logic      [7:0]        sci_control_two
);
	// ***************************************************************
	// pin front end
	// ***************************************************************
	logic pin_lvl;
	logic pin_rise;
	logic pin_fall;

	mcuis_pin_sync u_pin (
		.clk_sys (clk_sys),
		.rst     (rst),
		.pin     (irq_pin),
		.level   (pin_lvl),
		.rise    (pin_rise),
		.fall    (pin_fall)
	);

	// ***************************************************************
	// register file
	// ***************************************************************
	logic [7:0]  misc_int_config;
	logic [7:0]  next_misc;
	logic [7:0]  next_tctl;
	logic [7:0]  next_scc2;
	logic [31:0] next_prdata;
	logic        next_pready;
	logic        next_pslverr;
	logic        opt_chg;
	logic        wr_take;
	logic [7:0]  idx;
	logic [7:0]  rd_byte;
	logic        hit;
	logic        ext_latch;
	logic        ext_req;
	mcuis_pkg::mcuis_state_t state;

	assign idx     = 8'(paddr[ADDR_W-1:2]);
	// a write lands on the edge where the master sees pready
	assign wr_take = psel & penable & pready & pwrite;

	always_comb begin
		hit     = (paddr[1:0] == 2'b00);
		rd_byte = 8'h00;
		case (idx)
			mcuis_pkg::IDX_MISC: rd_byte = misc_int_config;
			mcuis_pkg::IDX_SCC2: rd_byte = sci_control_two;
			mcuis_pkg::IDX_SCIF: rd_byte = sci_flags_in;
			mcuis_pkg::IDX_TCTL: rd_byte = timer_control;
			mcuis_pkg::IDX_TFLG: rd_byte = tmr_flags_in;
			mcuis_pkg::IDX_STAT: rd_byte = {3'h0, state == mcuis_pkg::ST_WAIT,
				state == mcuis_pkg::ST_STOP, ext_req, ext_latch, int_mask_flag};
			default: hit = 1'b0;
		endcase
		next_pready  = psel & penable & ~pready;
		next_prdata  = next_pready ? {24'h0000_00, rd_byte} : prdata;
		next_pslverr = next_pready & ~hit;
		next_misc    = misc_int_config;
		next_tctl    = timer_control;
		next_scc2    = sci_control_two;
		opt_chg      = 1'b0;
		if (wr_take && hit) begin
			case (idx)
				mcuis_pkg::IDX_MISC: begin
					// options only move while masked, avoiding spurious edges
					if (int_mask_flag) begin
						next_misc[mcuis_pkg::MISC_POS] = pwdata[mcuis_pkg::MISC_POS];
						next_misc[mcuis_pkg::MISC_NEG] = pwdata[mcuis_pkg::MISC_NEG];
						next_misc[mcuis_pkg::MISC_EN]  = pwdata[mcuis_pkg::MISC_EN];
						opt_chg = (pwdata[mcuis_pkg::MISC_POS] !=
							misc_int_config[mcuis_pkg::MISC_POS]) |
							(pwdata[mcuis_pkg::MISC_NEG] !=
							misc_int_config[mcuis_pkg::MISC_NEG]);
					end
				end
				mcuis_pkg::IDX_TCTL: next_tctl = pwdata[7:0];
				mcuis_pkg::IDX_SCC2: next_scc2 = pwdata[7:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			misc_int_config <= mcuis_pkg::MISC_RST;
			timer_control   <= mcuis_pkg::TCTL_RST;
			sci_control_two <= mcuis_pkg::SCC2_RST;
			prdata          <= 32'h0000_0000;
			pready          <= 1'b0;
			pslverr         <= 1'b0;
		end else begin
			misc_int_config <= next_misc;
			timer_control   <= next_tctl;
			sci_control_two <= next_scc2;
			prdata          <= next_prdata;
			pready          <= next_pready;
			pslverr         <= next_pslverr;
		end
	end

	// ***************************************************************
	// request decode
	// ***************************************************************
	logic       sel_pos;
	logic       sel_neg;
	logic       ext_en;
	logic       edge_hit;
	logic       cap_req;
	logic       cmp_req;
	logic       ovf_req;
	logic       sci_req;
	logic       hw_any;

	assign sel_pos = misc_int_config[mcuis_pkg::MISC_POS];
	assign sel_neg = misc_int_config[mcuis_pkg::MISC_NEG];
	assign ext_en  = misc_int_config[mcuis_pkg::MISC_EN];
	assign edge_hit = sel_pos ? ((pin_rise) | (sel_neg & pin_fall)) : pin_fall;
	// with MISC_POS and MISC_NEG both clear, a low level keeps asking even once the latch is gone
	assign ext_req = ext_en & (ext_latch | (~sel_pos & ~sel_neg & ~pin_lvl));
	assign cap_req = timer_control[mcuis_pkg::TC_CAPIE] &
		(tmr_flags_in[mcuis_pkg::TF_CAP1] | tmr_flags_in[mcuis_pkg::TF_CAP2]);
	assign cmp_req = timer_control[mcuis_pkg::TC_CMPIE] &
		(tmr_flags_in[mcuis_pkg::TF_CMP1] | tmr_flags_in[mcuis_pkg::TF_CMP2]);
	assign ovf_req = timer_control[mcuis_pkg::TC_OVFIE] & tmr_flags_in[mcuis_pkg::TF_OVF];
	assign sci_req =
		(sci_control_two[mcuis_pkg::SC_TXEIE] & sci_flags_in[mcuis_pkg::SF_TXE]) |
		(sci_control_two[mcuis_pkg::SC_TXCIE] & sci_flags_in[mcuis_pkg::SF_TXC]) |
		(sci_control_two[mcuis_pkg::SC_RXIE]  & sci_flags_in[mcuis_pkg::SF_RXF]) |
		(sci_control_two[mcuis_pkg::SC_RXIE]  & sci_flags_in[mcuis_pkg::SF_OVR]) |
		(sci_control_two[mcuis_pkg::SC_IDLIE] & sci_flags_in[mcuis_pkg::SF_IDLE]);
	assign hw_any = ext_req | cap_req | cmp_req | ovf_req | sci_req;

	// ***************************************************************
	// sequencer
	// ***************************************************************
	mcuis_pkg::mcuis_state_t next_state;
	mcuis_pkg::mcuis_src_t   src;
	mcuis_pkg::mcuis_src_t   next_src;
	mcuis_pkg::mcuis_src_t   hw_src;
	logic [2:0]  cnt;
	logic [2:0]  next_cnt;
	logic [5:0]  sp;
	logic [5:0]  next_sp;
	logic        boot;
	logic        next_boot;
	logic        swi_pend;
	logic        next_swi_pend;
	logic        swi_snap;
	logic        next_swi_snap;
	logic        next_latch;
	logic        next_mask;
	logic        next_push;
	logic        next_vfetch;
	logic [15:0] next_vaddr;
	logic        next_osc;
	logic        next_cpu_clk;
	logic        next_tmr_clk;
	logic        take_hw;
	logic        take_swi;

	assign sp      = stack_ptr[5:0];
	// trap waits behind requests that were already pending at its fetch
	assign take_hw  = ~int_mask_flag & hw_any & (~swi_pend | swi_snap);
	assign take_swi = swi_pend & ~take_hw;

	always_comb begin
		hw_src = mcuis_pkg::SRC_SCI;
		if (ext_req) begin
			hw_src = mcuis_pkg::SRC_EXT;
		end else if (cap_req) begin
			hw_src = mcuis_pkg::SRC_CAP;
		end else if (cmp_req) begin
			hw_src = mcuis_pkg::SRC_CMP;
		end else if (ovf_req) begin
			hw_src = mcuis_pkg::SRC_OVF;
		end
	end

	always_comb begin
		next_state    = state;
		next_src      = src;
		next_cnt      = cnt;
		next_sp       = sp;
		next_boot     = 1'b0;
		next_swi_pend = swi_pend | soft_trap_fetch;
		next_swi_snap = soft_trap_fetch ? (~int_mask_flag & hw_any) : swi_snap;
		next_mask     = int_mask_flag;
		next_push     = 1'b0;
		next_vfetch   = 1'b0;
		next_vaddr    = vector_addr;
		next_osc      = osc_en;
		next_cpu_clk  = cpu_clk_en;
		next_tmr_clk  = timer_clk_en;
		next_latch    = ext_latch & ~opt_chg;
		if (mask_clr_exec) begin
			next_mask = 1'b0;
		end
		case (state)
			mcuis_pkg::ST_RUN: begin
				if (boot) begin
					next_vfetch = 1'b1;
					next_vaddr  = mcuis_pkg::VEC_RESET;
				end else if (instr_done && (take_hw || take_swi)) begin
					next_src   = take_hw ? hw_src : mcuis_pkg::SRC_SWI;
					next_state = mcuis_pkg::ST_PUSH;
					next_cnt   = 3'h0;
					next_push  = 1'b1;
					next_sp    = sp - 6'h01;
				end else if (trap_return_exec) begin
					next_mask = stacked_mask;
					next_sp   = sp + mcuis_pkg::ENTRY_WORDS;
				end else if (call_exec) begin
					next_sp = sp - mcuis_pkg::CALL_WORDS;
				end else if (return_exec) begin
					next_sp = sp + mcuis_pkg::CALL_WORDS;
				end else if (stop_exec) begin
					next_state   = mcuis_pkg::ST_STOP;
					next_mask    = 1'b0;
					next_osc     = 1'b0;
					next_cpu_clk = 1'b0;
					next_tmr_clk = 1'b0;
				end else if (wait_exec) begin
					next_state   = mcuis_pkg::ST_WAIT;
					next_mask    = 1'b0;
					next_cpu_clk = 1'b0;
				end
			end
			mcuis_pkg::ST_PUSH: begin
				if (cnt == mcuis_pkg::ENTRY_PUSHES - 3'h1) begin
					// mask goes up only after the last register is on the stack
					next_mask   = 1'b1;
					next_state  = mcuis_pkg::ST_RUN;
					next_vfetch = 1'b1;
					next_swi_snap = 1'b0;
					case (src)
						mcuis_pkg::SRC_EXT: begin
							next_vaddr = mcuis_pkg::VEC_EXT;
							next_latch = 1'b0;
						end
						mcuis_pkg::SRC_SWI: begin
							next_vaddr    = mcuis_pkg::VEC_SWI;
							next_swi_pend = soft_trap_fetch;
						end
						mcuis_pkg::SRC_CAP: next_vaddr = mcuis_pkg::VEC_CAP;
						mcuis_pkg::SRC_CMP: next_vaddr = mcuis_pkg::VEC_CMP;
						mcuis_pkg::SRC_OVF: next_vaddr = mcuis_pkg::VEC_OVF;
						default: next_vaddr = mcuis_pkg::VEC_SCI;
					endcase
				end else begin
					next_cnt  = cnt + 3'h1;
					next_push = 1'b1;
					next_sp   = sp - 6'h01;
				end
			end
			mcuis_pkg::ST_STOP: begin
				if (ext_req) begin
					next_state   = mcuis_pkg::ST_RUN;
					next_osc     = 1'b1;
					next_cpu_clk = 1'b1;
					next_tmr_clk = 1'b1;
				end
			end
			mcuis_pkg::ST_WAIT: begin
				if (hw_any) begin
					next_state   = mcuis_pkg::ST_RUN;
					next_cpu_clk = 1'b1;
				end
			end
			default: next_state = mcuis_pkg::ST_RUN;
		endcase
		// hardware and CPU sets win over a clear in the same cycle
		if (mask_set_exec) begin
			next_mask = 1'b1;
		end
		if (edge_hit) begin
			next_latch = 1'b1;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state         <= mcuis_pkg::ST_RUN;
			src           <= mcuis_pkg::SRC_EXT;
			cnt           <= 3'h0;
			stack_ptr     <= {mcuis_pkg::SP_PAGE, mcuis_pkg::SP_RST};
			boot          <= 1'b1;
			swi_pend      <= 1'b0;
			swi_snap      <= 1'b0;
			ext_latch     <= 1'b0;
			int_mask_flag <= 1'b1;
			stack_push    <= 1'b0;
			vector_fetch  <= 1'b0;
			vector_addr   <= mcuis_pkg::VEC_RESET;
			osc_en        <= 1'b1;
			cpu_clk_en    <= 1'b1;
			timer_clk_en  <= 1'b1;
		end else begin
			state         <= next_state;
			src           <= next_src;
			cnt           <= next_cnt;
			stack_ptr     <= {mcuis_pkg::SP_PAGE, next_sp};
			boot          <= next_boot;
			swi_pend      <= next_swi_pend;
			swi_snap      <= next_swi_snap;
			ext_latch     <= next_latch;
			int_mask_flag <= next_mask;
			stack_push    <= next_push;
			vector_fetch  <= next_vfetch;
			vector_addr   <= next_vaddr;
			osc_en        <= next_osc;
			cpu_clk_en    <= next_cpu_clk;
			timer_clk_en  <= next_tmr_clk;
		end
	end

	// ***************************************************************
	// checks
	// ***************************************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	sequence five_pushes;
		stack_push [*5] ##1 !stack_push;
	endsequence

	entry_sets_mask_a: assert property (
		(state == mcuis_pkg::ST_PUSH && cnt == 3'h4) |=> int_mask_flag && vector_fetch)
		else $error("mask not set after stacking");
	push_count_a: assert property ($rose(stack_push) |-> five_pushes)
		else $error("entry did not push five times");
	rti_restore_a: assert property (
		(state == mcuis_pkg::ST_RUN && !boot && trap_return_exec && !mask_set_exec &&
		!(instr_done && (take_hw || take_swi))) |=> int_mask_flag == $past(stacked_mask))
		else $error("return did not restore mask");
	masked_hold_a: assert property (
		(state == mcuis_pkg::ST_RUN && !boot && instr_done && int_mask_flag && !swi_pend)
		|=> state != mcuis_pkg::ST_PUSH)
		else $error("masked request was taken");
	ext_first_a: assert property (
		(state == mcuis_pkg::ST_RUN && !boot && instr_done && take_hw && ext_req)
		|-> ##6 vector_fetch && vector_addr == mcuis_pkg::VEC_EXT)
		else $error("pin request lost priority");
	trap_masked_a: assert property (
		(state == mcuis_pkg::ST_RUN && !boot && instr_done && swi_pend && int_mask_flag)
		|-> ##6 vector_fetch && vector_addr == mcuis_pkg::VEC_SWI)
		else $error("trap not taken under mask");
	opt_locked_a: assert property (
		(wr_take && idx == mcuis_pkg::IDX_MISC && !int_mask_flag) |=> $stable(misc_int_config))
		else $error("option changed while unmasked");
	opt_clears_a: assert property (
		(opt_chg && !edge_hit) |=> !ext_latch)
		else $error("option change kept request");
	stop_osc_a: assert property (
		(state == mcuis_pkg::ST_RUN && !boot && stop_exec && !instr_done && !trap_return_exec &&
		!call_exec && !return_exec) |=> !osc_en && state == mcuis_pkg::ST_STOP)
		else $error("stop left oscillator running");
endmodule : mcuis_ctrl

// [mcuis_pin_sync.sv]
`timescale 1ns/1ns
module mcuis_pin_sync (
	input  wire logic clk_sys,
	input  wire logic rst,
	input  wire logic pin,
	output logic      level,
	output logic      rise,
	output logic      fall
);
	logic s1;
	logic s2;
	logic s3;
	logic next_level;
	logic next_rise;
	logic next_fall;

	// a change counts only once the second and third stages agree
	always_comb begin
		next_level = level;
		if (s2 == s3) begin
			next_level = s3;
		end
		next_rise = next_level & ~level;
		next_fall = ~next_level & level;
	end

	// pin idles high; s1 is read by s2 only
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			s1    <= 1'b1;
			s2    <= 1'b1;
			s3    <= 1'b1;
			level <= 1'b1;
			rise  <= 1'b0;
			fall  <= 1'b0;
		end else begin
			s1    <= pin;
			s2    <= s1;
			s3    <= s2;
			level <= next_level;
			rise  <= next_rise;
			fall  <= next_fall;
		end
	end
endmodule : mcuis_pin_sync

// [mcuis_pkg.sv]
package mcuis_pkg;
	localparam logic [7:0] IDX_MISC = 8'h0C;
	localparam logic [7:0] IDX_SCC2 = 8'h0F;
	localparam logic [7:0] IDX_SCIF = 8'h10;
	localparam logic [7:0] IDX_TCTL = 8'h12;
	localparam logic [7:0] IDX_TFLG = 8'h13;
	localparam logic [7:0] IDX_STAT = 8'h14;

	localparam int MISC_POS = 6;
	localparam int MISC_NEG = 5;
	localparam int MISC_EN  = 4;
	localparam logic [7:0] MISC_RST = 8'h10;
	localparam logic [7:0] TCTL_RST = 8'h00;
	localparam logic [7:0] SCC2_RST = 8'h00;

	localparam int TF_CAP1 = 7;
	localparam int TF_CAP2 = 6;
	localparam int TF_CMP1 = 5;
	localparam int TF_CMP2 = 4;
	localparam int TF_OVF  = 3;
	localparam int TC_CAPIE = 7;
	localparam int TC_CMPIE = 6;
	localparam int TC_OVFIE = 5;
	localparam int SF_TXE  = 7;
	localparam int SF_TXC  = 6;
	localparam int SF_RXF  = 5;
	localparam int SF_IDLE = 4;
	localparam int SF_OVR  = 3;
	localparam int SC_TXEIE = 7;
	localparam int SC_TXCIE = 6;
	localparam int SC_RXIE  = 5;
	localparam int SC_IDLIE = 4;

	localparam logic [15:0] VEC_RESET = 16'h1FFE;
	localparam logic [15:0] VEC_SWI   = 16'h1FFC;
	localparam logic [15:0] VEC_EXT   = 16'h1FFA;
	localparam logic [15:0] VEC_CAP   = 16'h1FF8;
	localparam logic [15:0] VEC_CMP   = 16'h1FF6;
	localparam logic [15:0] VEC_OVF   = 16'h1FF4;
	localparam logic [15:0] VEC_SCI   = 16'h1FF2;

	localparam logic [9:0] SP_PAGE      = 10'h003;
	localparam logic [5:0] SP_RST       = 6'h3F;
	localparam logic [5:0] ENTRY_WORDS  = 6'h05;
	localparam logic [5:0] CALL_WORDS   = 6'h02;
	localparam logic [2:0] ENTRY_PUSHES = 3'h5;

	typedef enum logic [1:0] {ST_RUN, ST_PUSH, ST_STOP, ST_WAIT} mcuis_state_t;
	typedef enum logic [2:0] {SRC_EXT, SRC_SWI, SRC_CAP, SRC_CMP, SRC_OVF, SRC_SCI} mcuis_src_t;
endpackage : mcuis_pkg

// [test_mcu_interrupt_sequencer.sv]
`timescale 1ns/1ns
module test_mcu_interrupt_sequencer;
	logic        clk_sys, rst, psel, penable, pwrite, pready, pslverr, irq_pin, stacked_mask;
	logic        instr_done, int_mask_flag, stack_push, vector_fetch, osc_en, cpu_clk_en;
	logic        timer_clk_en, call_exec, return_exec, trap_return_exec, mask_set_exec;
	logic        mask_clr_exec, soft_trap_fetch, stop_exec, wait_exec, e;
	logic [9:0]  paddr;
	logic [31:0] pwdata, prdata;
	logic [7:0]  op, tmr_set, sci_set, tmr_flags_in, sci_flags_in, timer_control, q;
	logic [7:0]  sci_control_two;
	logic [15:0] stack_ptr, vector_addr;
	int          failures, check_count, vf_cnt, pc, v;

	assign {wait_exec, stop_exec, soft_trap_fetch, mask_clr_exec} = op[7:4];
	assign {mask_set_exec, trap_return_exec, return_exec, call_exec} = op[3:0];

	mcuis_ctrl DUT (
		.clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .irq_pin, .tmr_flags_in, .sci_flags_in, .instr_done, .soft_trap_fetch,
		.trap_return_exec, .stacked_mask, .mask_set_exec, .mask_clr_exec, .call_exec,
		.return_exec, .stop_exec, .wait_exec, .int_mask_flag, .stack_push, .stack_ptr,
		.vector_fetch, .vector_addr, .osc_en, .cpu_clk_en, .timer_clk_en, .timer_control,
		.sci_control_two
	);
	mcuis_cpu_model CPU (
		.clk_sys, .rst, .cpu_clk_en, .vector_fetch, .vector_addr, .tmr_set, .sci_set,
		.instr_done, .tmr_flags_in, .sci_flags_in
	);

	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	// counts move after the edge so a task reading them at that edge sees a settled value
	always @(posedge clk_sys) begin
		if (vector_fetch === 1'b1) vf_cnt <= vf_cnt + 1;
		if (stack_push === 1'b1) pc <= pc + 1;
	end

	// ***
	// shared tasks
	// ***
	task chk(input logic [15:0] got, input logic [15:0] x);
		check_count++;
		if (got !== x) begin
			failures++;
			$display("MISMATCH %0t got %h expected %h", $time, got, x);
		end
	endtask : chk

	// waits for pready however long it takes; only the watchdog ends a hung access
	task apb(input logic wr, input logic [9:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h00_0000, d};
		@(posedge clk_sys);
		penable <= 1'b1;
		@(posedge clk_sys);
		while (pready !== 1'b1) begin
			@(posedge clk_sys);
		end
		q = prdata[7:0];
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task rd(input logic [9:0] a, input logic [7:0] x);
		apb(1'b0, a, 8'h00);
		chk({8'h00, q}, {8'h00, x});
	endtask : rd

	// cpu pulse, then one edge so its effect is visible on return
	task go(input logic [7:0] o, input logic m);
		@(posedge clk_sys);
		op <= o;
		stacked_mask <= m;
		@(posedge clk_sys);
		op <= 8'h00;
		@(posedge clk_sys);
	endtask : go

	task tset(input logic [7:0] t, input logic [7:0] s);
		@(posedge clk_sys);
		tmr_set <= t;
		sci_set <= s;
		@(posedge clk_sys);
		tmr_set <= 8'h00;
		sci_set <= 8'h00;
	endtask : tset

	// short low pulse: falling edge at the start, rising edge at the end
	task pin;
		@(posedge clk_sys);
		irq_pin <= 1'b0;
		repeat (4) @(posedge clk_sys);
		irq_pin <= 1'b1;
	endtask : pin

	task vec(input logic [15:0] x);
		int n;
		n = 0;
		@(posedge clk_sys);
		while (vector_fetch !== 1'b1 && n < 200) begin
			n++;
			@(posedge clk_sys);
		end
		chk(vector_fetch === 1'b1 ? vector_addr : 16'h0000, x);
	endtask : vec

	task no_vec;
		v = vf_cnt;
		repeat (40) @(posedge clk_sys);
		chk(16'(vf_cnt - v), 16'h0000);
	endtask : no_vec

	task close_out;
		if (failures == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : close_out

	initial begin
		#2000000;
		failures++;
		close_out();
	end

	// ***
	// scenarios
	// ***
	initial begin
		{psel, penable, pwrite, stacked_mask} = 4'h0;
		irq_pin = 1'b1;
		rst = 1'b1;
		paddr = 10'h000;
		pwdata = 32'h0000_0000;
		{op, tmr_set, sci_set} = 24'h00_0000;
		{failures, check_count, vf_cnt, pc} = '0;
		repeat (10) @(posedge clk_sys);
		rst <= 1'b0;
		chk(vector_addr, 16'h1FFE);
		chk({15'h0000, int_mask_flag}, 16'h0001);
		rd(10'h030, 8'h10);
		rd(10'h048, 8'h00);
		rd(10'h03C, 8'h00);
		rd(10'h050, 8'h01);
		apb(1'b0, 10'h004, 8'h00);
		chk({15'h0000, e}, 16'h0001);
		apb(1'b1, 10'h040, 8'hFF);
		rd(10'h040, 8'h00);
		apb(1'b1, 10'h048, 8'hE0);
		apb(1'b1, 10'h03C, 8'hF0);
		rd(10'h048, 8'hE0);
		chk({8'h00, sci_control_two}, 16'h00F0);
		tset(8'h20, 8'h00);
		pin();
		no_vec();
		go(8'h10, 1'b0);
		vec(16'h1FFA);
		chk(stack_ptr, 16'h00FA);
		chk(16'(pc), 16'h0005);
		chk({15'h0000, int_mask_flag}, 16'h0001);
		apb(1'b1, 10'h030, 8'h50);
		rd(10'h030, 8'h50);
		go(8'h04, 1'b0);
		chk({15'h0000, int_mask_flag}, 16'h0000);
		chk(stack_ptr, 16'h00FF);
		vec(16'h1FF6);
		go(8'h04, 1'b0);
		pin();
		vec(16'h1FFA);
		go(8'h04, 1'b0);
		apb(1'b1, 10'h030, 8'h30);
		rd(10'h030, 8'h50);
		for (int i = 0; i < 5; i++) begin
			tset(8'h80 >> i, 8'h00);
			vec(i < 2 ? 16'h1FF8 : i < 4 ? 16'h1FF6 : 16'h1FF4);
			go(8'h04, 1'b0);
			tset(8'h00, 8'h80 >> i);
			vec(16'h1FF2);
			go(8'h04, 1'b0);
		end
		go(8'h08, 1'b0);
		go(8'h20, 1'b0);
		vec(16'h1FFC);
		apb(1'b1, 10'h030, 8'h00);
		pin();
		apb(1'b1, 10'h030, 8'h10);
		go(8'h04, 1'b0);
		vec(16'h1FFA);
		pin();
		apb(1'b1, 10'h030, 8'h30);
		go(8'h04, 1'b0);
		no_vec();
		go(8'h40, 1'b0);
		chk({12'h000, osc_en, cpu_clk_en, timer_clk_en, int_mask_flag}, 16'h0000);
		pin();
		vec(16'h1FFA);
		chk({15'h0000, osc_en}, 16'h0001);
		go(8'h04, 1'b0);
		go(8'h80, 1'b0);
		chk({14'h0000, cpu_clk_en, timer_clk_en}, 16'h0001);
		tset(8'h08, 8'h00);
		vec(16'h1FF4);
		go(8'h04, 1'b0);
		go(8'h01, 1'b0);
		chk(stack_ptr, 16'h00FD);
		go(8'h02, 1'b0);
		go(8'h08, 1'b0);
		apb(1'b1, 10'h030, 8'h70);
		@(posedge clk_sys);
		irq_pin <= 1'b0;
		go(8'h10, 1'b0);
		vec(16'h1FFA);
		apb(1'b1, 10'h030, 8'h10);
		go(8'h04, 1'b0);
		vec(16'h1FFA);
		apb(1'b1, 10'h030, 8'h70);
		go(8'h04, 1'b0);
		@(posedge clk_sys);
		irq_pin <= 1'b1;
		vec(16'h1FFA);
		go(8'h04, 1'b0);
		close_out();
	end
endmodule : test_mcu_interrupt_sequencer
